// ==== uart_dma_pkg.sv ====
// package: register map, field positions and timing constants for the dma serial port
package uart_dma_pkg;
  localparam int SYS_CLK_MHZ = 200;
  localparam int REF_CLK_MHZ = 24;
  localparam int FIFO_DEPTH = 4;
  localparam logic [31:0] RAM_BASE = 32'h2000_0000;
  localparam logic [31:0] RX_BEG_A_OFS = 32'h4000_c800;
  localparam logic [31:0] RX_BEG_B_OFS = 32'h4000_c804;
  localparam logic [31:0] RX_END_A_OFS = 32'h4000_c808;
  localparam logic [31:0] RX_END_B_OFS = 32'h4000_c80c;
  localparam logic [31:0] TX_BEG_A_OFS = 32'h4000_c810;
  localparam logic [31:0] TX_END_A_OFS = 32'h4000_c814;
  localparam logic [31:0] TX_BEG_B_OFS = 32'h4000_c818;
  localparam logic [31:0] TX_END_B_OFS = 32'h4000_c81c;
  localparam logic [31:0] RX_CNT_A_OFS = 32'h4000_c820;
  localparam logic [31:0] RX_CNT_B_OFS = 32'h4000_c824;
  localparam logic [31:0] TX_CNT_OFS = 32'h4000_c828;
  localparam logic [31:0] DMA_STAT_OFS = 32'h4000_c82c;
  localparam logic [31:0] DMA_CTRL_OFS = 32'h4000_c830;
  localparam logic [31:0] DATA_PORT_OFS = 32'h4000_c83c;
  localparam logic [31:0] UART_STATUS_OFS = 32'h4000_c848;
  localparam logic [31:0] UART_CONFIG_OFS = 32'h4000_c85c;
  localparam logic [31:0] BAUD_INT_OFS = 32'h4000_c868;
  localparam logic [31:0] BAUD_FRAC_OFS = 32'h4000_c86c;
  // config field positions
  localparam int CFG_SOFT_RTS = 0;
  localparam int CFG_EIGHT = 1;
  localparam int CFG_TWO_STOP = 2;
  localparam int CFG_PAR_EN = 3;
  localparam int CFG_ODD = 4;
  localparam int CFG_FLOW = 5;
  localparam int CFG_AUTO = 6;
  // dma control field positions
  localparam int CTL_RX_LOD_A = 0;
  localparam int CTL_TX_LOD_A = 2;
  localparam int CTL_RX_RST = 4;
  localparam int CTL_TX_RST = 5;
  localparam logic [6:0] CONFIG_RESET = 7'h00;
  localparam logic [15:0] BAUD_INT_RESET = 16'h0000;
  localparam logic [13:0] DMA_ADDR_RESET = 14'h0000;
  localparam logic [31:0] UART_STATUS_RESET = 32'h0000_0040;
  typedef enum logic [4:0] {
    TX_IDLE = 5'h01, TX_START = 5'h02, TX_DATA = 5'h04, TX_PARITY = 5'h08, TX_STOP = 5'h10
  } tx_state_type;
  typedef enum logic [4:0] {
    RX_IDLE = 5'h01, RX_START = 5'h02, RX_DATA = 5'h04, RX_PARITY = 5'h08, RX_STOP = 5'h10
  } rx_state_type;
endpackage : uart_dma_pkg

// ==== serial_uart_with_dma.sv ====
// serial transceiver with ping-pong dma channels, wishbone registers and memory port
//
// Notes on behaviour
// - transmitter-idle flag high only with transmit queue and shifter both empty.
// - parity/frame flags describe head byte; refreshed on data read, low when empty.
// - byte arriving at full receive queue sets overrun; data read clears it.
// - transmit-space flag high while transmit queue has a free slot.
// - receive-valid flag high while receive queue holds a byte.
// - clear-to-send state reads 1 when the pin is low.
// - automatic mode drops request when receive room is one or less.
// - flow control off means clear-to-send is ignored.
// - parity enable adds a parity bit; odd select picks odd, else even.
// - two-stop select sends two stop bits, else one.
// - eight-bit select picks eight data bits, else seven, both directions.
// - software request bit drives request pin when flow on and auto off.
// - bit rate is 24 MHz divided by twice integer plus fraction.
// - each channel has buffers A and B and switches between them automatically.
// - end address may be rewritten while buffer loaded or active.
// - transmit keeps one shared offset, receive one offset per buffer.
// - offsets hold until their buffer loads or the channel resets; the transmit offset also clears when its buffer unloads.
// - writing a receive offset also loads that buffer, keeping the value.
// - buffer unloads once start plus offset passes the end address.
// - software writes meeting that condition unload the buffer at once.
// - simultaneous load uses A first; load bits read 1 while pending or active.
// - dma reset bits reset their channel and read back zero.
// - frame is low start, data lsb first, optional parity, stop bits, idle high.
// - with flow on, a character starts only while clear-to-send is low; one in progress finishes.
//
// Decided for this implementation: register access over Wishbone.
`timescale 1ns/1ps
module serial_uart_with_dma import uart_dma_pkg::*; #(
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [31:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  output logic txd,
  input wire logic rxd,
  output logic request_to_send_n,
  input wire logic clear_to_send_n,
  output logic mem_req,
  output logic mem_we,
  output logic [13:0] mem_addr,
  output logic [7:0] mem_wdata,
  input wire logic [7:0] mem_rdata,
  input wire logic mem_ack
);
  localparam int PW = $clog2(DEPTH);
  localparam logic [PW:0] DEPTH_C = (PW+1)'(DEPTH);

  logic [6:0] cfg_reg;
  logic [15:0] baud_int_reg;
  logic baud_frac_reg;
  logic [7:0] ref_acc_reg;
  logic [7:0] tx_mem [DEPTH];
  logic [9:0] rx_mem [DEPTH];
  logic [PW-1:0] tx_wr_reg, tx_rd_reg, rx_wr_reg, rx_rd_reg;
  logic [PW:0] tx_count_reg, rx_count_reg;
  logic par_flag_reg, frm_flag_reg, rx_ovf_reg;
  logic [13:0] tx_beg_reg [2];
  logic [13:0] tx_end_reg [2];
  logic [13:0] rx_beg_reg [2];
  logic [13:0] rx_end_reg [2];
  logic [13:0] rx_cnt_reg [2];
  logic [13:0] tx_cnt_reg;
  logic [1:0] tx_lod_reg, rx_lod_reg, rx_par_err_reg, rx_frm_err_reg;
  logic tx_sel_reg, rx_sel_reg, mem_rx_reg;
  tx_state_type tx_state_reg;
  rx_state_type rx_state_reg;
  logic [16:0] tx_tick_reg, rx_tick_reg;
  logic [2:0] tx_idx_reg, rx_idx_reg;
  logic [7:0] tx_shift_reg, rx_shift_reg;
  logic tx_par_reg, rx_par_reg;

  wire flow = cfg_reg[CFG_FLOW];
  wire eight = cfg_reg[CFG_EIGHT];
  wire odd = cfg_reg[CFG_ODD];
  wire par_en = cfg_reg[CFG_PAR_EN];

  // bus decode
  wire acc = cyc_i & stb_i & ~ack_o;
  wire wr = acc & we_i & (sel_i == 4'hf);
  wire rd = acc & ~we_i;
  wire hit_data = adr_i == DATA_PORT_OFS;
  wire hit_ctrl = adr_i == DMA_CTRL_OFS;
  wire [1:0] hit_rx_cnt = {adr_i == RX_CNT_B_OFS, adr_i == RX_CNT_A_OFS};

  // 24 MHz reference as a fractional enable from the 200 MHz clock
  wire [8:0] ref_sum = {1'b0, ref_acc_reg} + 9'(REF_CLK_MHZ);
  wire ref_tick = ref_sum >= 9'(SYS_CLK_MHZ);
  wire [7:0] ref_acc_next = ref_tick ? 8'(ref_sum - 9'(SYS_CLK_MHZ)) : ref_sum[7:0];
  wire [16:0] period_raw = {baud_int_reg, 1'b0} + {16'h0000, baud_frac_reg};
  wire [16:0] period = (period_raw == 17'h00000) ? 17'h00001 : period_raw;
  wire [16:0] half = (period[16:1] == 16'h0000) ? 17'h00001 : {1'b0, period[16:1]};
  wire tx_bit_end = ref_tick & (tx_tick_reg >= period - 17'h00001);
  wire rx_bit_end = ref_tick & (rx_tick_reg >= period - 17'h00001);
  wire rx_half_end = ref_tick & (rx_tick_reg >= half - 17'h00001);
  wire [2:0] last_bit = eight ? 3'h7 : 3'h6;

  // queues
  wire tx_full = tx_count_reg == DEPTH_C;
  wire tx_empty = tx_count_reg == '0;
  wire rx_full = rx_count_reg == DEPTH_C;
  wire rx_empty = rx_count_reg == '0;
  wire [9:0] rx_head = rx_mem[rx_rd_reg];
  wire mem_done = mem_req & mem_ack;
  wire dma_tx_push = mem_done & ~mem_rx_reg;
  wire dma_rx_pop = mem_done & mem_rx_reg;
  wire sw_tx_push = wr & hit_data & ~tx_full & ~dma_tx_push;
  wire tx_push = dma_tx_push | sw_tx_push;
  wire cts_ok = ~flow | ~clear_to_send_n;
  wire tx_pop = (tx_state_reg == TX_IDLE) & ~tx_empty & cts_ok;
  wire rx_done = (rx_state_reg == RX_STOP) & rx_bit_end;
  wire rx_push = rx_done & ~rx_full;
  wire sw_rx_pop = rd & hit_data & ~rx_empty & ~(mem_req & mem_rx_reg);
  wire rx_pop = dma_rx_pop | sw_rx_pop;
  wire [PW:0] rx_count_next = rx_count_reg + (PW+1)'(rx_push) - (PW+1)'(rx_pop);
  wire [PW-1:0] rx_rd_inc = rx_rd_reg + PW'(1);
  wire [PW:0] rx_room = DEPTH_C - rx_count_reg;

  // status and flags
  wire tx_all_empty_flag = tx_empty & (tx_state_reg == TX_IDLE);
  wire tx_space_flag = ~tx_full;
  wire rx_valid_flag = ~rx_empty;
  wire clear_to_send_state = ~clear_to_send_n;
  wire [7:0] status = {1'b0, tx_all_empty_flag, par_flag_reg, frm_flag_reg, rx_ovf_reg,
    tx_space_flag, rx_valid_flag, clear_to_send_state};
  wire rts_auto = (rx_room > (PW+1)'(1)) ? 1'b0 : 1'b1;
  wire rts_next = ~flow ? 1'b1 : cfg_reg[CFG_AUTO] ? rts_auto : ~cfg_reg[CFG_SOFT_RTS];

  // dma control decode
  wire tx_rst = wr & hit_ctrl & dat_i[CTL_TX_RST];
  wire rx_rst = wr & hit_ctrl & dat_i[CTL_RX_RST];
  wire [1:0] tx_load = (wr & hit_ctrl) ? dat_i[CTL_TX_LOD_A +: 2] : 2'b00;
  wire [1:0] rx_load_wr = (wr & hit_ctrl) ? dat_i[CTL_RX_LOD_A +: 2] : 2'b00;
  wire [1:0] rx_cnt_wr = wr ? hit_rx_cnt : 2'b00;
  wire [1:0] rx_load = rx_load_wr | rx_cnt_wr;

  // unload test runs every cycle, so an end or offset write takes effect at once
  wire [14:0] tx_sum = {1'b0, tx_beg_reg[tx_sel_reg]} + {1'b0, tx_cnt_reg};
  wire tx_cur = tx_lod_reg[tx_sel_reg];
  wire tx_unload = tx_cur & (tx_sum > {1'b0, tx_end_reg[tx_sel_reg]});
  wire [1:0] tx_clr = tx_unload ? (tx_sel_reg ? 2'b10 : 2'b01) : 2'b00;
  wire [1:0] tx_lod_next = (tx_lod_reg & ~tx_clr) | tx_load;
  wire [14:0] rx_sum = {1'b0, rx_beg_reg[rx_sel_reg]} + {1'b0, rx_cnt_reg[rx_sel_reg]};
  wire rx_cur = rx_lod_reg[rx_sel_reg];
  wire rx_unload = rx_cur & (rx_sum > {1'b0, rx_end_reg[rx_sel_reg]});
  wire [1:0] rx_clr = rx_unload ? (rx_sel_reg ? 2'b10 : 2'b01) : 2'b00;
  wire [1:0] rx_lod_next = (rx_lod_reg & ~rx_clr) | rx_load;
  wire rx_go = rx_cur & ~rx_unload & ~rx_empty & ~rx_rst;
  // one slot kept back so a software push during the fetch cannot overfill the queue
  wire tx_go = tx_cur & ~tx_unload & (tx_count_reg < DEPTH_C - (PW+1)'(1)) & ~tx_rst;

  // register read mux
  wire [31:0] rd_word =
    hit_data ? {24'h0, rx_head[7:0]} :
    (adr_i == UART_STATUS_OFS) ? {24'h0, status} :
    (adr_i == UART_CONFIG_OFS) ? {25'h0, cfg_reg} :
    (adr_i == BAUD_INT_OFS) ? {16'h0, baud_int_reg} :
    (adr_i == BAUD_FRAC_OFS) ? {31'h0, baud_frac_reg} :
    hit_ctrl ? {28'h0, tx_lod_reg, rx_lod_reg} :
    (adr_i == DMA_STAT_OFS) ? {22'h0, rx_frm_err_reg, rx_par_err_reg, 2'b00,
      tx_lod_reg & {tx_sel_reg, ~tx_sel_reg}, rx_lod_reg & {rx_sel_reg, ~rx_sel_reg}} :
    (adr_i == TX_CNT_OFS) ? {18'h0, tx_cnt_reg} :
    hit_rx_cnt[0] ? {18'h0, rx_cnt_reg[0]} :
    hit_rx_cnt[1] ? {18'h0, rx_cnt_reg[1]} :
    (adr_i == TX_BEG_A_OFS) ? RAM_BASE | {18'h0, tx_beg_reg[0]} :
    (adr_i == TX_BEG_B_OFS) ? RAM_BASE | {18'h0, tx_beg_reg[1]} :
    (adr_i == TX_END_A_OFS) ? RAM_BASE | {18'h0, tx_end_reg[0]} :
    (adr_i == TX_END_B_OFS) ? RAM_BASE | {18'h0, tx_end_reg[1]} :
    (adr_i == RX_BEG_A_OFS) ? RAM_BASE | {18'h0, rx_beg_reg[0]} :
    (adr_i == RX_BEG_B_OFS) ? RAM_BASE | {18'h0, rx_beg_reg[1]} :
    (adr_i == RX_END_A_OFS) ? RAM_BASE | {18'h0, rx_end_reg[0]} :
    (adr_i == RX_END_B_OFS) ? RAM_BASE | {18'h0, rx_end_reg[1]} : 32'h0;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0;
      request_to_send_n <= 1'b1;
      ref_acc_reg <= 8'h00;
    end else begin
      ack_o <= acc;
      if (rd) dat_o <= rd_word;
      request_to_send_n <= rts_next;
      ref_acc_reg <= ref_acc_next;
    end
  end

  // software configuration; end addresses stay writable while loaded
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cfg_reg <= CONFIG_RESET;
      baud_int_reg <= BAUD_INT_RESET;
      baud_frac_reg <= 1'b0;
      for (int i = 0; i < 2; i++) begin
        tx_beg_reg[i] <= DMA_ADDR_RESET;
        tx_end_reg[i] <= DMA_ADDR_RESET;
        rx_beg_reg[i] <= DMA_ADDR_RESET;
        rx_end_reg[i] <= DMA_ADDR_RESET;
      end
    end else if (wr) begin
      if (adr_i == UART_CONFIG_OFS) cfg_reg <= dat_i[6:0];
      if (adr_i == BAUD_INT_OFS) baud_int_reg <= dat_i[15:0];
      if (adr_i == BAUD_FRAC_OFS) baud_frac_reg <= dat_i[0];
      if (adr_i == TX_BEG_A_OFS) tx_beg_reg[0] <= dat_i[13:0];
      if (adr_i == TX_BEG_B_OFS) tx_beg_reg[1] <= dat_i[13:0];
      if (adr_i == TX_END_A_OFS) tx_end_reg[0] <= dat_i[13:0];
      if (adr_i == TX_END_B_OFS) tx_end_reg[1] <= dat_i[13:0];
      if (adr_i == RX_BEG_A_OFS) rx_beg_reg[0] <= dat_i[13:0];
      if (adr_i == RX_BEG_B_OFS) rx_beg_reg[1] <= dat_i[13:0];
      if (adr_i == RX_END_A_OFS) rx_end_reg[0] <= dat_i[13:0];
      if (adr_i == RX_END_B_OFS) rx_end_reg[1] <= dat_i[13:0];
    end
  end

  // queues and receive flags
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      tx_wr_reg <= '0;
      tx_rd_reg <= '0;
      tx_count_reg <= '0;
      rx_wr_reg <= '0;
      rx_rd_reg <= '0;
      rx_count_reg <= '0;
      par_flag_reg <= 1'b0;
      frm_flag_reg <= 1'b0;
      rx_ovf_reg <= 1'b0;
    end else begin
      if (tx_push) begin
        tx_mem[tx_wr_reg] <= dma_tx_push ? mem_rdata : dat_i[7:0];
        tx_wr_reg <= tx_wr_reg + PW'(1);
      end
      if (tx_pop) tx_rd_reg <= tx_rd_reg + PW'(1);
      tx_count_reg <= tx_count_reg + (PW+1)'(tx_push) - (PW+1)'(tx_pop);
      if (rx_push) begin
        rx_mem[rx_wr_reg] <= {~rxd, rx_par_reg, rx_shift_reg};
        rx_wr_reg <= rx_wr_reg + PW'(1);
      end
      if (rx_pop) rx_rd_reg <= rx_rd_inc;
      rx_count_reg <= rx_count_next;
      if (rx_count_next == '0) begin
        par_flag_reg <= 1'b0;
        frm_flag_reg <= 1'b0;
      end else if (rx_pop && rx_count_reg > (PW+1)'(1)) begin
        {frm_flag_reg, par_flag_reg} <= rx_mem[rx_rd_inc][9:8];
      end else if (rx_push && (rx_empty || rx_pop)) begin
        {frm_flag_reg, par_flag_reg} <= {~rxd, rx_par_reg};
      end
      if (rx_done && rx_full) rx_ovf_reg <= 1'b1;
      else if (rd && hit_data) rx_ovf_reg <= 1'b0;
    end
  end

  // transmit channel: one shared offset, A preferred when both are pending
  always_ff @(posedge clk_sys) begin
    if (!rst_n || tx_rst) begin
      tx_lod_reg <= 2'b00;
      tx_sel_reg <= 1'b0;
      tx_cnt_reg <= 14'h0000;
    end else begin
      tx_lod_reg <= tx_lod_next;
      if (tx_unload) begin
        tx_sel_reg <= ~tx_sel_reg;
        tx_cnt_reg <= 14'h0000;
      end else if (!tx_cur) begin
        tx_sel_reg <= ~tx_lod_next[0] & tx_lod_next[1];
        if (tx_load != 2'b00) tx_cnt_reg <= 14'h0000;
      end else if (dma_tx_push) begin
        tx_cnt_reg <= tx_cnt_reg + 14'h0001;
      end
    end
  end

  // receive channel: an offset per buffer and per-buffer error marks
  always_ff @(posedge clk_sys) begin
    if (!rst_n || rx_rst) begin
      rx_lod_reg <= 2'b00;
      rx_sel_reg <= 1'b0;
      rx_par_err_reg <= 2'b00;
      rx_frm_err_reg <= 2'b00;
      for (int i = 0; i < 2; i++) rx_cnt_reg[i] <= 14'h0000;
    end else begin
      rx_lod_reg <= rx_lod_next;
      if (rx_unload) rx_sel_reg <= ~rx_sel_reg;
      else if (!rx_cur) rx_sel_reg <= ~rx_lod_next[0] & rx_lod_next[1];
      for (int i = 0; i < 2; i++) begin
        if (rx_cnt_wr[i]) rx_cnt_reg[i] <= dat_i[13:0];
        else if (rx_load_wr[i]) rx_cnt_reg[i] <= 14'h0000;
        else if (dma_rx_pop && rx_sel_reg == 1'(i)) rx_cnt_reg[i] <= rx_cnt_reg[i] + 14'h0001;
        if (rx_load[i]) begin
          rx_par_err_reg[i] <= 1'b0;
          rx_frm_err_reg[i] <= 1'b0;
        end
        if (dma_rx_pop && rx_sel_reg == 1'(i)) begin
          if (rx_head[8]) rx_par_err_reg[i] <= 1'b1;
          if (rx_head[9]) rx_frm_err_reg[i] <= 1'b1;
        end
      end
    end
  end

  // single memory port, receive served first since its queue can overrun
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_rx_reg <= 1'b0;
      mem_addr <= 14'h0000;
      mem_wdata <= 8'h00;
    end else if (mem_req) begin
      if (mem_ack) mem_req <= 1'b0;
    end else if (rx_go) begin
      mem_req <= 1'b1;
      mem_we <= 1'b1;
      mem_rx_reg <= 1'b1;
      mem_addr <= rx_sum[13:0];
      mem_wdata <= rx_head[7:0];
    end else if (tx_go) begin
      mem_req <= 1'b1;
      mem_we <= 1'b0;
      mem_rx_reg <= 1'b0;
      mem_addr <= tx_sum[13:0];
    end
  end

  // transmitter
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      tx_state_reg <= TX_IDLE;
      txd <= 1'b1;
      tx_tick_reg <= 17'h00000;
      tx_idx_reg <= 3'h0;
      tx_shift_reg <= 8'h00;
      tx_par_reg <= 1'b0;
    end else begin
      tx_tick_reg <= (tx_bit_end || tx_state_reg == TX_IDLE) ? 17'h00000 : tx_tick_reg + 17'(ref_tick);
      case (tx_state_reg)
        TX_IDLE: if (tx_pop) begin
          tx_state_reg <= TX_START;
          txd <= 1'b0;
          tx_shift_reg <= tx_mem[tx_rd_reg];
          tx_par_reg <= ^(tx_mem[tx_rd_reg] & {eight, 7'h7f}) ^ odd;
          tx_idx_reg <= 3'h0;
        end
        TX_START: if (tx_bit_end) begin
          tx_state_reg <= TX_DATA;
          txd <= tx_shift_reg[0];
        end
        TX_DATA: if (tx_bit_end) begin
          tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
          tx_idx_reg <= tx_idx_reg + 3'h1;
          txd <= tx_shift_reg[1];
          if (tx_idx_reg == last_bit) begin
            tx_idx_reg <= 3'h0;
            tx_state_reg <= par_en ? TX_PARITY : TX_STOP;
            txd <= par_en ? tx_par_reg : 1'b1;
          end
        end
        TX_PARITY: if (tx_bit_end) begin
          tx_state_reg <= TX_STOP;
          txd <= 1'b1;
        end
        TX_STOP: if (tx_bit_end) begin
          if (cfg_reg[CFG_TWO_STOP] && tx_idx_reg == 3'h0) tx_idx_reg <= 3'h1;
          else tx_state_reg <= TX_IDLE;
        end
        default: tx_state_reg <= TX_IDLE;
      endcase
    end
  end

  // receiver, sampling mid-bit; only one stop bit is checked
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rx_state_reg <= RX_IDLE;
      rx_tick_reg <= 17'h00000;
      rx_idx_reg <= 3'h0;
      rx_shift_reg <= 8'h00;
      rx_par_reg <= 1'b0;
    end else begin
      rx_tick_reg <= rx_tick_reg + 17'(ref_tick);
      case (rx_state_reg)
        RX_IDLE: begin
          rx_tick_reg <= 17'h00000;
          rx_idx_reg <= 3'h0;
          rx_shift_reg <= 8'h00;
          if (!rxd) rx_state_reg <= RX_START;
        end
        RX_START: if (rx_half_end) begin
          rx_tick_reg <= 17'h00000;
          rx_state_reg <= rxd ? RX_IDLE : RX_DATA;
        end
        RX_DATA: if (rx_bit_end) begin
          rx_tick_reg <= 17'h00000;
          rx_shift_reg[rx_idx_reg] <= rxd;
          rx_idx_reg <= rx_idx_reg + 3'h1;
          rx_par_reg <= 1'b0;
          if (rx_idx_reg == last_bit) rx_state_reg <= par_en ? RX_PARITY : RX_STOP;
        end
        RX_PARITY: if (rx_bit_end) begin
          rx_tick_reg <= 17'h00000;
          rx_par_reg <= rxd ^ (^rx_shift_reg) ^ odd;
          rx_state_reg <= RX_STOP;
        end
        RX_STOP: if (rx_bit_end) rx_state_reg <= RX_IDLE;
        default: rx_state_reg <= RX_IDLE;
      endcase
    end
  end

  property p_tx_idle;
    @(posedge clk_sys) disable iff (!rst_n) tx_all_empty_flag |-> txd;
  endproperty
  a_tx_idle: assert property (p_tx_idle) else $error("idle flag while line busy");
  property p_err_empty;
    @(posedge clk_sys) disable iff (!rst_n) rx_empty |-> !par_flag_reg && !frm_flag_reg;
  endproperty
  a_err_empty: assert property (p_err_empty) else $error("error flag with empty queue");
  property p_overrun;
    @(posedge clk_sys) disable iff (!rst_n) rx_done && rx_full |=> rx_ovf_reg;
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun not flagged");
  property p_rts_auto;
    @(posedge clk_sys) disable iff (!rst_n) flow && cfg_reg[CFG_AUTO] && rx_room <= (PW+1)'(1) |=> request_to_send_n;
  endproperty
  a_rts_auto: assert property (p_rts_auto) else $error("request held with no room");
  property p_rts_soft;
    @(posedge clk_sys) disable iff (!rst_n) flow && !cfg_reg[CFG_AUTO] |=> request_to_send_n == !$past(cfg_reg[CFG_SOFT_RTS]);
  endproperty
  a_rts_soft: assert property (p_rts_soft) else $error("request pin ignores software bit");
  property p_cts_start;
    @(posedge clk_sys) disable iff (!rst_n) $rose(tx_state_reg == TX_START) |-> !$past(flow) || !$past(clear_to_send_n);
  endproperty
  a_cts_start: assert property (p_cts_start) else $error("character began without clear to send");
  property p_unload;
    @(posedge clk_sys) disable iff (!rst_n) tx_unload && tx_load == 2'b00 && !tx_rst |=> !tx_lod_reg[$past(tx_sel_reg)];
  endproperty
  a_unload: assert property (p_unload) else $error("buffer past its end stayed loaded");
  property p_rst_clears;
    @(posedge clk_sys) disable iff (!rst_n) rx_rst |=> rx_lod_reg == 2'b00 && rx_cnt_reg[0] == 14'h0000;
  endproperty
  a_rst_clears: assert property (p_rst_clears) else $error("receive channel not reset");
  property p_start_bit;
    @(posedge clk_sys) disable iff (!rst_n) tx_state_reg == TX_START |-> !txd;
  endproperty
  a_start_bit: assert property (p_start_bit) else $error("start bit not low");
endmodule : serial_uart_with_dma

// ==== serial_far_end.sv ====
// far-side model: ram behind the memory port and a looped-back serial device
`timescale 1ns/1ps
module serial_far_end (
  input wire logic clk_sys,
  input wire logic txd,
  output logic rxd,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [13:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  output logic [7:0] mem_rdata,
  output logic mem_ack
);
  logic [7:0] ram [0:255];
  // the line loops back, so every received frame carries the transmitter's framing
  assign rxd = txd;
  initial mem_ack = 1'b0;
  initial mem_rdata = 8'h00;
  always @(posedge clk_sys) begin
    mem_ack <= mem_req && !mem_ack;
    // read data is inverted once the answer is gone so stale bytes never look valid
    mem_rdata <= mem_ack ? ~mem_rdata : ram[mem_addr[7:0]];
    if (mem_req && mem_we && !mem_ack) ram[mem_addr[7:0]] <= mem_wdata;
  end
endmodule : serial_far_end

// ==== testbench.sv ====
// self-checking bench: status, configuration, flow-control pins and looped-back framing
`timescale 1ns/1ps
module testbench;
  import uart_dma_pkg::*;
  logic clk_sys = 0, rst_n = 0, cyc_i = 0, stb_i = 0, we_i = 0, clear_to_send_n = 1;
  logic [31:0] adr_i = 0, dat_i = 0, dat_o, q;
  logic [3:0] sel_i = 4'hf;
  logic ack_o, txd, rxd, request_to_send_n, mem_req, mem_we, mem_ack;
  logic [13:0] mem_addr;
  logic [7:0] mem_wdata, mem_rdata, b, c;
  logic [6:0] modes [5] = '{7'h02, 7'h00, 7'h0a, 7'h1a, 7'h06};
  int miscompares = 0, comparisons = 0;
  serial_uart_with_dma serial_uart_with_dma_i (.clk_sys(clk_sys), .rst_n(rst_n), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
    .ack_o(ack_o), .txd(txd), .rxd(rxd), .request_to_send_n(request_to_send_n),
    .clear_to_send_n(clear_to_send_n), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack));
  serial_far_end serial_far_end_i (.clk_sys(clk_sys), .txd(txd), .rxd(rxd), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
    .mem_ack(mem_ack));
  initial forever #2.5 clk_sys = ~clk_sys;
  task wrap_up;
    $display("counts: %0d mismatches in %0d comparisons", miscompares, comparisons);
    if (miscompares == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : wrap_up
  // received word as the data port shows it: seven-bit mode reads bit 7 as zero
  function automatic logic [31:0] rx_word(input logic [6:0] mode, input logic [7:0] d);
    return mode[CFG_EIGHT] ? {24'h0, d} : {25'h0, d[6:0]};
  endfunction : rx_word
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask : chk
  // entered just after a rising edge; ack and read data are taken at the same edge
  task wb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    cyc_i <= 1;
    stb_i <= 1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    n = 0;
    do begin @(posedge clk_sys); n++; end while (ack_o !== 1'b1 && n < 50);
    if (ack_o !== 1'b1) begin miscompares++; wrap_up(); end
    q = dat_o;
    cyc_i <= 0;
    stb_i <= 0;
    @(posedge clk_sys);
  endtask : wb
  task wait_bit(input logic [31:0] a, input int k);
    int n;
    n = 0;
    do begin wb(0, a, 0); n++; end while (q[k] !== 1'b1 && n < 600);
    if (q[k] !== 1'b1) begin miscompares++; wrap_up(); end
  endtask : wait_bit
  initial begin
    void'($urandom(32'h0cf21c19));
    repeat (10) @(posedge clk_sys);
    rst_n <= 1;
    @(posedge clk_sys);
    wb(0, UART_STATUS_OFS, 0);
    chk(q & 32'hffff_fffb, UART_STATUS_RESET);
    chk(q[2], 1'b1);
    clear_to_send_n <= 0;
    wb(0, UART_STATUS_OFS, 0);
    chk(q[0], 1'b1);
    wb(0, 32'h4000_c8f0, 0);
    chk(q, 0);
    wb(1, DMA_CTRL_OFS, 32'h30);
    wb(0, DMA_CTRL_OFS, 0);
    chk(q, 0);
    wb(1, UART_CONFIG_OFS, 32'h21);
    chk(request_to_send_n, 1'b0);
    wb(1, UART_CONFIG_OFS, 32'h20);
    chk(request_to_send_n, 1'b1);
    $display("test registers done");
    wb(1, BAUD_INT_OFS, 1);
    // clear-to-send held high with flow off must not stall any mode
    clear_to_send_n <= 1;
    for (int m = 0; m < 5; m++) begin
      b = 8'($urandom());
      wb(1, UART_CONFIG_OFS, {25'h0, modes[m]});
      wb(0, UART_CONFIG_OFS, 0);
      chk(q, {25'h0, modes[m]});
      wb(1, DATA_PORT_OFS, {24'h0, b});
      wb(0, UART_STATUS_OFS, 0);
      chk(q[6], 1'b0);
      wait_bit(UART_STATUS_OFS, 1);
      chk(q[5:4], 2'b00);
      wb(0, DATA_PORT_OFS, 0);
      chk(q, rx_word(modes[m], b));
      wb(0, UART_STATUS_OFS, 0);
      chk(q[1], 1'b0);
    end
    $display("test framing done");
    wb(1, UART_CONFIG_OFS, 32'h22);
    b = 8'($urandom());
    wb(1, DATA_PORT_OFS, {24'h0, b});
    repeat (400) @(posedge clk_sys);
    wb(0, UART_STATUS_OFS, 0);
    chk(q[1], 1'b0);
    clear_to_send_n <= 0;
    // clear-to-send rises again once the character has begun; it must still finish
    wb(0, UART_STATUS_OFS, 0);
    clear_to_send_n <= 1;
    wait_bit(UART_STATUS_OFS, 1);
    wb(0, DATA_PORT_OFS, 0);
    chk(q, {24'h0, b});
    $display("test clear to send done");
    clear_to_send_n <= 0;
    wb(1, DMA_CTRL_OFS, 32'h30);
    wb(1, RX_BEG_A_OFS, 32'h2000_0010);
    wb(1, RX_END_A_OFS, 32'h2000_0011);
    wb(1, RX_BEG_B_OFS, 32'h2000_0020);
    wb(1, RX_END_B_OFS, 32'h2000_002f);
    wb(1, DMA_CTRL_OFS, 32'h03);
    b = 8'($urandom());
    c = 8'($urandom());
    wb(1, DATA_PORT_OFS, {24'h0, b});
    wb(1, DATA_PORT_OFS, {24'h0, c});
    wait_bit(DMA_STAT_OFS, 1);
    chk(serial_far_end_i.ram[8'h10], b);
    chk(serial_far_end_i.ram[8'h11], c);
    wb(0, RX_CNT_A_OFS, 0);
    chk(q, 2);
    wb(0, DMA_CTRL_OFS, 0);
    chk(q, 32'h2);
    wb(1, TX_BEG_A_OFS, 32'h2000_0010);
    wb(1, TX_END_A_OFS, 32'h2000_0011);
    wb(1, DMA_CTRL_OFS, 32'h04);
    wait_bit(RX_CNT_B_OFS, 1);
    chk(serial_far_end_i.ram[8'h20], b);
    chk(serial_far_end_i.ram[8'h21], c);
    wb(0, DMA_CTRL_OFS, 0);
    chk(q, 32'h2);
    wb(1, RX_END_B_OFS, 32'h2000_0020);
    wb(0, DMA_CTRL_OFS, 0);
    chk(q, 0);
    wb(1, RX_CNT_A_OFS, 1);
    wb(0, RX_CNT_A_OFS, 0);
    chk(q, 1);
    wb(0, DMA_CTRL_OFS, 0);
    chk(q, 1);
    wb(1, DMA_CTRL_OFS, 32'h30);
    $display("test dma done");
    wb(1, UART_CONFIG_OFS, 32'h62);
    chk(request_to_send_n, 1'b0);
    for (int i = 0; i < 5; i++) wb(1, DATA_PORT_OFS, 32'($urandom() & 8'hff));
    wait_bit(UART_STATUS_OFS, 3);
    chk(request_to_send_n, 1'b1);
    wb(0, DATA_PORT_OFS, 0);
    wb(0, UART_STATUS_OFS, 0);
    chk(q[3], 1'b0);
    $display("test overrun done");
    wrap_up();
  end
endmodule : testbench
